/* File: common/sbc_regs_pkg.sv */
// shared constants and types for the serial configuration/diagnosis registers
package sbc_regs_pkg;
    // frame layout, least significant bit shifted first
    localparam int FRAME_W  = 16;
    localparam int CNT_W    = 4;
    localparam int DATA_W   = 10;
    localparam int MODE_LSB = 0;
    localparam int CFG_LSB  = 3;
    localparam int DATA_LSB = 6;

    typedef logic [2:0] cfg_t;
    typedef logic [DATA_W-1:0] data_t;

    // configuration select codes
    localparam cfg_t CFG_WAKE     = 3'h3;
    localparam cfg_t CFG_CONFIG   = 3'h4;
    localparam cfg_t CFG_LINK     = 3'h5;
    localparam cfg_t CFG_WATCHDOG = 3'h6;
    localparam cfg_t CFG_DIAG     = 3'h7;

    // mode selection code of the read-only command
    localparam logic [2:0] MODE_READ_ONLY = 3'h7;

    // link_setup fields
    localparam int LINK_MODE_LSB = 0;
    localparam logic [1:0] LINK_MODE_RST = 2'h0;

    // watchdog_control fields
    localparam int WD_PERIOD_LSB  = 0;
    localparam int WD_TIMEOUT_BIT = 5;
    localparam int WD_RSVD_BIT    = 6;
    localparam int WD_ENABLE_BIT  = 7;
    localparam int WD_PARITY_BIT  = 8;
    localparam logic [4:0] WD_PERIOD_RST = 5'h0f;
    localparam logic WD_TIMEOUT_RST = 1'b1;
    localparam logic WD_ENABLE_RST  = 1'b1;

    // configuration register fields
    localparam int THRESH_LSB      = 0;
    localparam int FALLBACK_ON_BIT = 2;
    localparam int FAIL_TO_FB_BIT  = 3;
    localparam logic [1:0] THRESH_RST = 2'h1;
    localparam logic [1:0] THRESH_INVALID = 2'h0;
    localparam logic FALLBACK_ON_RST = 1'b0;
    localparam logic FAIL_TO_FB_RST  = 1'b1;

    // diagnosis fields
    localparam int RESTART_LSB  = 0;
    localparam int FB_CAUSE_LSB = 2;
    localparam int SETUP_LSB    = 5;
    localparam int DIAG_FTF_BIT = 8;
    localparam int SETUP_DEV_BIT = 2;

    // watchdog period arithmetic in ms
    localparam int PERIOD_SPLIT      = 16;
    localparam int PERIOD_STEP_LO_MS = 16;
    localparam int PERIOD_STEP_HI_MS = 48;
    localparam int PERIOD_OFFS_HI_MS = 464;

    // mode the device held before entering normal mode
    typedef enum logic [2:0] {
        PRIOR_SLEEP,
        PRIOR_FAIL_SAFE,
        PRIOR_RESTART_FAIL,
        PRIOR_RESTART_HOST,
        PRIOR_INIT
    } prior_mode_t;
endpackage

/* File: common/spi_view_if.sv */
// words passed between the register core and the serial link logic
`timescale 1ns/1ps
interface spi_view_if;
    logic [9:0]  view [0:7];   // frozen register words, stable in a frame
    logic [15:0] next_tx;      // reply frame for non read-only commands
    logic [15:0] rx_word;      // last complete received frame
    logic        rx_toggle;    // flips once per complete frame

    modport core (output view, output next_tx,
                  input rx_word, input rx_toggle);
    modport link (input view, input next_tx,
                  output rx_word, output rx_toggle);
endinterface

/* File: rtl/spi_link.sv */
// serial shifter running on the host's serial clock
`timescale 1ns/1ps
module spi_link
    import sbc_regs_pkg::*;
(
    input  wire logic spi_clk_in,
    input  wire logic spi_cs_n_in,
    input  wire logic link_rst_in,
    input  wire logic spi_data_in,
    output logic      spi_data_out,
    output logic      spi_data_oe_out,
    spi_view_if.link  bus
);
    logic [CNT_W-1:0]   bit_cnt_reg;
    logic [FRAME_W-1:0] rx_shift_reg;
    logic [FRAME_W-1:0] rx_word_reg;
    logic               rx_toggle_reg;
    logic [5:0]         hdr_reg;
    logic [FRAME_W-1:0] rx_full;
    logic               ro_frame;
    logic [CNT_W-1:0]   data_idx;

    // bit counter restarts with every chip select, clock may stop between
    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    assign rx_full = {spi_data_in, rx_shift_reg[FRAME_W-1:1]};

    // lsb first shift; only whole frames are handed over
    always_ff @(posedge spi_clk_in) begin
        rx_shift_reg <= rx_full;
        if (bit_cnt_reg == CNT_W'(DATA_LSB - 1)) begin
            hdr_reg <= rx_full[FRAME_W-1:FRAME_W-6];
        end
    end

    // toggle handshake: word stays put until the next whole frame
    always_ff @(posedge spi_clk_in or posedge link_rst_in) begin
        if (link_rst_in) begin
            rx_word_reg   <= '0;
            rx_toggle_reg <= 1'b0;
        end else if (bit_cnt_reg == CNT_W'(FRAME_W - 1)) begin
            rx_word_reg   <= rx_full;
            rx_toggle_reg <= ~rx_toggle_reg;
        end
    end

    assign bus.rx_word   = rx_word_reg;
    assign bus.rx_toggle = rx_toggle_reg;

    // read-only answers in this frame, everything else replays last request
    assign ro_frame = (hdr_reg[2:0] == MODE_READ_ONLY);
    assign data_idx = bit_cnt_reg - CNT_W'(DATA_LSB);
    always_comb begin
        if (bit_cnt_reg < CNT_W'(DATA_LSB) || !ro_frame) begin
            spi_data_out = bus.next_tx[bit_cnt_reg];
        end else begin
            spi_data_out = bus.view[hdr_reg[5:3]][data_idx];
        end
    end
    assign spi_data_oe_out = ~spi_cs_n_in;
endmodule

/* File: rtl/sbc_spi_regs.sv */
// configuration, watchdog and diagnosis registers behind the serial port
`timescale 1ns/1ps
module sbc_spi_regs
    import sbc_regs_pkg::*;
(
    input  wire logic                       sys_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       spi_clk_in,
    input  wire logic                       spi_cs_n_in,
    input  wire logic                       spi_data_in,
    output logic                            spi_data_out,
    output logic                            spi_data_oe_out,
    input  wire logic [2:0]                 mode_bits_in,
    input  wire logic                       enter_normal_in,
    input  wire sbc_regs_pkg::prior_mode_t  prior_mode_in,
    input  wire logic                       restart_event_in,
    input  wire logic [1:0]                 restart_code_in,
    input  wire logic                       fallback_event_in,
    input  wire logic [2:0]                 fallback_code_in,
    input  wire logic [2:0]                 setup_strap_in,
    input  wire sbc_regs_pkg::data_t        wake_word_in,
    output logic [1:0]                      transceiver_mode_out,
    output logic                            wd_timeout_mode_out,
    output logic                            wd_enable_out,
    output logic [4:0]                      wd_period_code_out,
    output logic [10:0]                     wd_period_ms_out,
    output logic [1:0]                      threshold_sel_out,
    output logic                            fallback_on_out,
    output logic                            failures_to_fallback_out,
    output logic                            dev_mode_out,
    output logic                            wd_trigger_out,
    output logic                            wd_parity_error_out
);
    import sbc_regs_pkg::*;
    spi_view_if bus ();
    // period in ms for a 5-bit code
    function automatic logic [10:0] period_ms(input logic [4:0] n);
        int v;
        if (int'(n) < PERIOD_SPLIT) begin
            v = (int'(n) + 1) * PERIOD_STEP_LO_MS;
        end else begin
            v = int'(n) * PERIOD_STEP_HI_MS - PERIOD_OFFS_HI_MS;
        end
        return v[10:0];
    endfunction

    logic [1:0]  link_mode_reg;
    logic [4:0]  wd_period_reg;
    logic        wd_timeout_reg;
    logic        wd_enable_reg;
    logic [1:0]  thresh_reg;
    logic        fb_on_reg;
    logic        ftf_reg;
    logic [1:0]  restart_reg;
    logic [2:0]  fb_cause_reg;
    logic [2:0]  strap_meta_reg;
    logic [2:0]  strap_sync_reg;
    logic [2:0]  setup_reg;
    logic        strap_done_reg;
    logic        cs_meta_reg;
    logic        cs_idle_reg;
    logic        tog_meta_reg;
    logic        tog_sync_reg;
    logic        tog_prev_reg;
    logic        link_rst_reg;
    cfg_t        sel_reg;
    logic        first_frame_reg;
    logic        trigger_reg;
    logic        parity_err_reg;
    logic [10:0] period_ms_reg;
    data_t       live_word [0:7];

    // names for the frame just received
    logic        frame_pulse;
    logic [2:0]  rx_mode;
    cfg_t        rx_cfg;
    data_t       rx_data;
    logic        is_ro;
    logic        wr;
    logic        parity_ok;
    logic        wr_link;
    logic        wr_wd;
    logic        wr_config;
    logic        fb_switch_off;
    logic        clr_restart;
    logic        wd_parity;

    assign frame_pulse = tog_sync_reg ^ tog_prev_reg;
    assign rx_mode     = bus.rx_word[CFG_LSB-1:MODE_LSB];
    assign rx_cfg      = bus.rx_word[DATA_LSB-1:CFG_LSB];
    assign rx_data     = bus.rx_word[FRAME_W-1:DATA_LSB];
    assign is_ro       = (rx_mode == MODE_READ_ONLY);
    assign wr          = frame_pulse && !is_ro;
    assign parity_ok   = ((^rx_data[WD_ENABLE_BIT:0])
                          == rx_data[WD_PARITY_BIT]);
    assign wr_link     = wr && rx_cfg == CFG_LINK;
    assign wr_wd       = wr && rx_cfg == CFG_WATCHDOG && parity_ok;
    assign wr_config   = wr && rx_cfg == CFG_CONFIG;
    assign fb_switch_off = wr_config && fb_on_reg
                           && !rx_data[FALLBACK_ON_BIT];
    // explicit readouts clear; a first frame after normal entry does not
    assign clr_restart = (frame_pulse && is_ro && rx_cfg == CFG_DIAG)
                      || (wr && !first_frame_reg && sel_reg == CFG_DIAG)
                      || (enter_normal_in && (prior_mode_in == PRIOR_SLEEP
                          || prior_mode_in == PRIOR_FAIL_SAFE));

    // read-back words; reserved watchdog bit always reads as one
    assign wd_parity = ^{wd_enable_reg, 1'b1, wd_timeout_reg, wd_period_reg};
    always_comb begin
        live_word = '{default: '0};
        live_word[CFG_WAKE]     = wake_word_in;
        live_word[CFG_CONFIG]   = {6'h00, ftf_reg, fb_on_reg, thresh_reg};
        live_word[CFG_LINK]     = {8'h00, link_mode_reg};
        live_word[CFG_WATCHDOG] = {1'b0, wd_parity, wd_enable_reg, 1'b1,
                                   wd_timeout_reg, wd_period_reg};
        live_word[CFG_DIAG]     = {1'b0, ftf_reg, setup_reg, fb_cause_reg,
                                   restart_reg};
    end

    // pin-side levels and the frame toggle pass two flops first
    always_ff @(posedge sys_clk_in) begin
        cs_meta_reg    <= spi_cs_n_in;
        cs_idle_reg    <= cs_meta_reg;
        tog_meta_reg   <= bus.rx_toggle;
        tog_sync_reg   <= tog_meta_reg;
        strap_meta_reg <= setup_strap_in;
        strap_sync_reg <= strap_meta_reg;
    end
    // frame edge detector and link reset level
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tog_prev_reg <= 1'b0;
            link_rst_reg <= 1'b1;
        end else begin
            tog_prev_reg <= tog_sync_reg;
            link_rst_reg <= 1'b0;
        end
    end
    // snapshot only while idle, so the link never sees a word change
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bus.view    <= '{default: '0};
            bus.next_tx <= '0;
        end else if (cs_idle_reg) begin
            bus.view    <= live_word;
            bus.next_tx <= {live_word[sel_reg], sel_reg, mode_bits_in};
        end
    end
    // strap caught once, after the release of reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            setup_reg      <= '0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            setup_reg      <= strap_sync_reg;
            strap_done_reg <= 1'b1;
        end
    end
    // transceiver mode
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            link_mode_reg <= LINK_MODE_RST;
        end else if (wr_link) begin
            link_mode_reg <= rx_data[LINK_MODE_LSB +: 2];
        end
    end
    // watchdog settings, bad parity keeps the last valid set
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wd_period_reg  <= WD_PERIOD_RST;
            wd_timeout_reg <= WD_TIMEOUT_RST;
            wd_enable_reg  <= WD_ENABLE_RST;
        end else if (wr_wd) begin
            wd_period_reg  <= rx_data[WD_PERIOD_LSB +: 5];
            wd_timeout_reg <= rx_data[WD_TIMEOUT_BIT];
            wd_enable_reg  <= rx_data[WD_ENABLE_BIT];
        end
    end
    // configuration register: threshold, fallback output, failure count
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            thresh_reg <= THRESH_RST;
            fb_on_reg  <= FALLBACK_ON_RST;
            ftf_reg    <= FAIL_TO_FB_RST;
        end else begin
            if (wr_config && rx_data[THRESH_LSB +: 2] != THRESH_INVALID) begin
                thresh_reg <= rx_data[THRESH_LSB +: 2];
            end
            if (fallback_event_in) begin
                fb_on_reg <= 1'b1;
            end else if (wr_config) begin
                fb_on_reg <= rx_data[FALLBACK_ON_BIT];
            end
            if (wr_config) begin
                ftf_reg <= rx_data[FAIL_TO_FB_BIT];
            end
        end
    end
    // diagnosis flags: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            restart_reg  <= '0;
            fb_cause_reg <= '0;
        end else begin
            if (restart_event_in) begin
                restart_reg <= restart_code_in;
            end else if (clr_restart) begin
                restart_reg <= '0;
            end
            // fallback cause is live state: reading never clears it
            if (fallback_event_in) begin
                fb_cause_reg <= fallback_code_in;
            end else if (fb_switch_off) begin
                fb_cause_reg <= '0;
            end
        end
    end
    // reply selection for the next frame
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sel_reg         <= CFG_CONFIG;
            first_frame_reg <= 1'b0;
        end else if (enter_normal_in) begin
            first_frame_reg <= 1'b1;
            case (prior_mode_in)
                PRIOR_SLEEP:        sel_reg <= CFG_WAKE;
                PRIOR_FAIL_SAFE:    sel_reg <= CFG_DIAG;
                PRIOR_RESTART_FAIL: sel_reg <= CFG_DIAG;
                default:            sel_reg <= CFG_CONFIG;
            endcase
        end else if (frame_pulse) begin
            first_frame_reg <= 1'b0;
            if (!is_ro) begin
                sel_reg <= rx_cfg;
            end
        end
    end
    // trigger, parity error and period outputs
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            trigger_reg    <= 1'b0;
            parity_err_reg <= 1'b0;
            period_ms_reg  <= period_ms(WD_PERIOD_RST);
        end else begin
            trigger_reg    <= (frame_pulse && is_ro) || wr_wd;
            parity_err_reg <= wr && rx_cfg == CFG_WATCHDOG && !parity_ok;
            period_ms_reg  <= period_ms(wd_period_reg);
        end
    end

    spi_link u_link (
        .spi_clk_in      (spi_clk_in),
        .spi_cs_n_in     (spi_cs_n_in),
        .link_rst_in     (link_rst_reg),
        .spi_data_in     (spi_data_in),
        .spi_data_out    (spi_data_out),
        .spi_data_oe_out (spi_data_oe_out),
        .bus             (bus.link)
    );
    assign transceiver_mode_out     = link_mode_reg;
    assign wd_timeout_mode_out      = wd_timeout_reg;
    assign wd_enable_out            = wd_enable_reg;
    assign wd_period_code_out       = wd_period_reg;
    assign wd_period_ms_out         = period_ms_reg;
    assign threshold_sel_out        = thresh_reg;
    assign fallback_on_out          = fb_on_reg;
    assign failures_to_fallback_out = ftf_reg;
    assign dev_mode_out             = setup_reg[SETUP_DEV_BIT];
    assign wd_trigger_out           = trigger_reg;
    assign wd_parity_error_out      = parity_err_reg;

    // checks on the system clock side
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_ro_frame;
        frame_pulse && is_ro;
    endsequence
    sequence s_bad_wd_write;
        wr && rx_cfg == CFG_WATCHDOG && !parity_ok;
    endsequence

    AST_RO_NO_WRITE: assert property (
        s_ro_frame |=> $stable(link_mode_reg) && $stable(wd_period_reg)
                       && $stable(thresh_reg) && $stable(ftf_reg))
        else $error("read-only command changed a register");
    AST_RO_TRIGGER: assert property (
        s_ro_frame |=> wd_trigger_out ##1 !wd_trigger_out || frame_pulse)
        else $error("read-only command gave no watchdog trigger");
    AST_PARITY_REJECT: assert property (
        s_bad_wd_write |=> $stable(wd_period_reg) && $stable(wd_enable_reg)
                           && wd_parity_error_out)
        else $error("watchdog write with bad parity was taken");
    AST_THRESH_HOLD: assert property (
        wr_config && rx_data[1:0] == 2'h0 |=> $stable(thresh_reg))
        else $error("invalid threshold code changed the threshold");
    AST_LINK_WRITE: assert property (
        wr_link |=> link_mode_reg == $past(rx_data[1:0]))
        else $error("transceiver mode not written");
    AST_RESTART_RO_CLEAR: assert property (
        s_ro_frame ##0 rx_cfg == CFG_DIAG && !restart_event_in
        |=> restart_reg == 2'h0)
        else $error("restart cause not cleared by read-only read");
    AST_FB_CLEAR: assert property (
        fb_switch_off && !fallback_event_in |=> fb_cause_reg == 3'h0
                                                && !fallback_on_out)
        else $error("fallback cause not cleared on switch off");
    AST_FIRST_SLEEP: assert property (
        enter_normal_in && prior_mode_in == PRIOR_SLEEP
        |=> sel_reg == CFG_WAKE && first_frame_reg)
        else $error("first frame after sleep not the wake register");
    AST_FIRST_NO_CLEAR: assert property (
        wr && first_frame_reg && !restart_event_in && !enter_normal_in
        |=> $stable(restart_reg))
        else $error("first frame cleared the restart cause");
endmodule

/* File: sim/spi_host_model.sv */
// host-side serial master model that shifts frames lsb first
`timescale 1ns/1ps
module spi_host_model (
    output logic      spi_clk_out,
    output logic      spi_cs_n_out,
    output logic      spi_data_out,
    input  wire logic spi_data_in
);
    logic [15:0] rx_word;
    // clock stands low outside frames, data rests at its pull-down level
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_data_out = 1'b0;
    end
    // reply bit sampled just before the rising edge, where it has settled
    task automatic xfer(input logic [15:0] tx);
        spi_cs_n_out = 1'b0;
        #250;
        for (int i = 0; i < 16; i++) begin
            spi_data_out = tx[i];
            #24;
            rx_word[i] = spi_data_in;
            spi_clk_out = 1'b1;
            #24;
            spi_clk_out = 1'b0;
        end
        #250;
        spi_cs_n_out = 1'b1;
        spi_data_out = 1'b0;
        #400; // cs high long enough for the reply snapshot
    endtask
endmodule

/* File: sim/sbc_spi_config_diag_regs_tb.sv */
// self-checking bench for the configuration and diagnosis registers
`timescale 1ns/1ps
module sbc_spi_config_diag_regs_tb;
    import sbc_regs_pkg::*;
    logic        clk, rst, sck, csn, sdi, sdo, en, rev, fev, to, wen;
    logic        fon, ftf, dev, trg, per, oe;
    logic [1:0]  rc, xm, th;
    logic [2:0]  mb, fc, st;
    logic [4:0]  wc;
    logic [10:0] ms;
    prior_mode_t pm;
    data_t       ww;
    int          fails = 0, num_checks = 0, trg_n = 0, per_n = 0, t0;
    int          oe_bad = 0;
    int          pc[4] = '{0, 15, 16, 31};
    sbc_spi_regs u_dut (.sys_clk_in(clk), .rst_in(rst), .spi_clk_in(sck),
        .spi_cs_n_in(csn), .spi_data_in(sdi), .spi_data_out(sdo),
        .spi_data_oe_out(oe), .mode_bits_in(mb), .enter_normal_in(en),
        .prior_mode_in(pm), .restart_event_in(rev), .restart_code_in(rc),
        .fallback_event_in(fev), .fallback_code_in(fc),
        .setup_strap_in(st), .wake_word_in(ww), .transceiver_mode_out(xm),
        .wd_timeout_mode_out(to), .wd_enable_out(wen),
        .wd_period_code_out(wc), .wd_period_ms_out(ms),
        .threshold_sel_out(th), .fallback_on_out(fon),
        .failures_to_fallback_out(ftf), .dev_mode_out(dev),
        .wd_trigger_out(trg), .wd_parity_error_out(per));
    spi_host_model u_host (.spi_clk_out(sck), .spi_cs_n_out(csn),
        .spi_data_out(sdi), .spi_data_in(sdo));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // one-cycle pulses are counted away from the edge that launches them
    always @(negedge clk) begin
        if (trg === 1'b1) trg_n++;
        if (per === 1'b1) per_n++;
        if (oe !== ~csn) oe_bad++;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [15:0] frm(logic [2:0] m, cfg_t s, data_t d);
        return {d, s, m};
    endfunction
    // watchdog word with reserved bit set and parity over data bits 7..0
    function automatic logic [15:0] wdw(logic [4:0] p, logic o, logic e);
        logic [7:0] d;
        d = {e, 1'b1, o, p};
        return frm(3'h0, CFG_WATCHDOG, {1'b0, ^d, d});
    endfunction
    // send one frame and compare the whole reply word
    task automatic xf(input logic [15:0] tx, input cfg_t s, input data_t d);
        u_host.xfer(tx);
        check(u_host.rx_word, {d, s, mb});
    endtask
    task automatic ev(input logic r, f, n, input prior_mode_t p);
        @(posedge clk);
        #1;
        {rev, fev, en} = {r, f, n};
        pm = p;
        @(posedge clk);
        #1;
        {rev, fev, en} = 3'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    initial begin
        #500000;
        fails++;
        results();
    end
    initial begin
        rst = 1'b1;
        {en, rev, fev} = 3'h0;
        rc = 2'h2;
        fc = 3'h5;
        mb = 3'h6;
        st = 3'h5;
        ww = 10'h2a5;
        pm = PRIOR_INIT;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        // reset word: link 00, wd 1/1/0f, thresh 01, fb 0, ftf 1, dev 1
        check({xm, to, wen, wc, th, fon, ftf, dev, 2'h0}, 16'h37ac);
        check({5'h0, ms}, 16'h0100);
        xf(frm(3'h0, CFG_LINK, 10'h000), CFG_CONFIG, 10'h009);
        for (int k = 1; k < 4; k++) begin
            xf(frm(3'h0, CFG_LINK, data_t'(k)), CFG_LINK, data_t'(k-1));
            check({14'h0, xm}, 16'(k));
        end
        t0 = trg_n;
        xf(frm(3'h7, CFG_LINK, 10'h000), CFG_LINK, 10'h003);
        check({14'h0, xm}, 16'h0003);
        check(16'(trg_n - t0), 16'h0001);
        foreach (pc[i]) begin
            u_host.xfer(wdw(5'(pc[i]), 1'b0, 1'b1));
            t0 = pc[i] < 16 ? (pc[i] + 1) * 16 : pc[i] * 48 - 464;
            check({5'h0, ms}, 16'(t0));
        end
        check({to, wen, 14'h0}, 16'h4000);
        t0 = per_n;
        u_host.xfer(wdw(5'h03, 1'b1, 1'b0) ^ 16'h4000);
        check({5'h0, ms}, 16'h0400);
        check(16'(per_n - t0), 16'h0001);
        u_host.xfer(frm(3'h0, CFG_CONFIG, 10'h00b));
        u_host.xfer(frm(3'h0, CFG_CONFIG, 10'h000));
        check({13'h0, ftf, th}, 16'h0003);
        ev(1'b1, 1'b1, 1'b0, PRIOR_INIT);
        check({15'h0, fon}, 16'h0001);
        // a read-only header still carries the previous request's select
        xf(frm(3'h7, CFG_DIAG, 10'h000), CFG_CONFIG, 10'h0b6);
        xf(frm(3'h7, CFG_DIAG, 10'h000), CFG_CONFIG, 10'h0b4);
        u_host.xfer(frm(3'h0, CFG_CONFIG, 10'h003));
        xf(frm(3'h7, CFG_DIAG, 10'h000), CFG_CONFIG, 10'h0a0);
        // first frame after normal entry picks its register by prior mode
        ev(1'b0, 1'b0, 1'b1, PRIOR_SLEEP);
        xf(frm(3'h0, CFG_LINK, 10'h003), CFG_WAKE, ww);
        ev(1'b1, 1'b0, 1'b0, PRIOR_RESTART_FAIL);
        ev(1'b0, 1'b0, 1'b1, PRIOR_RESTART_FAIL);
        xf(frm(3'h0, CFG_LINK, 10'h003), CFG_DIAG, 10'h0a2);
        xf(frm(3'h7, CFG_DIAG, 10'h000), CFG_LINK, 10'h0a2);
        ev(1'b1, 1'b0, 1'b0, PRIOR_FAIL_SAFE);
        ev(1'b0, 1'b0, 1'b1, PRIOR_FAIL_SAFE);
        xf(frm(3'h0, CFG_LINK, 10'h003), CFG_DIAG, 10'h0a0);
        ev(1'b0, 1'b0, 1'b1, PRIOR_INIT);
        xf(frm(3'h0, CFG_LINK, 10'h003), CFG_CONFIG, 10'h003);
        ev(1'b0, 1'b0, 1'b1, PRIOR_RESTART_HOST);
        xf(frm(3'h0, CFG_LINK, 10'h003), CFG_CONFIG, 10'h003);
        check(16'(oe_bad), 16'h0000);
        results();
    end
endmodule
